// *** rx_dma_pkg.sv ***
// Purpose: Shared constants and types for the receive DMA read channel.
// Assumes: Byte-wide register port with a 16-bit address, one 20 MHz clock.
// Notes:   Every offset, field position and reset value is named here once.
package rx_dma_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register offsets on the register port.
  localparam logic [15:0] CONFIG_OFFSET = 16'h011B;
  localparam logic [15:0] STATUS_OFFSET = 16'h0120;

  // Field positions inside the configuration register.
  localparam int unsigned CFG_RESET_BIT  = 7;
  localparam int unsigned CFG_ENABLE_BIT = 6;
  localparam int unsigned CFG_ROLE_BIT   = 5;
  localparam int unsigned CFG_CHAN_LSB   = 0;
  localparam int unsigned CFG_CHAN_W     = 3;

  // Reset value and the bits that software can store; reserved bits 4:3 read as zero.
  localparam logic [7:0] CONFIG_RESET      = 8'h00;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'hE7;

  // Channel select codes.
  localparam logic [2:0] CHANNEL_ZERO = 3'h0;

  // Field positions inside the status register.
  localparam int unsigned STS_REQUEST_BIT  = 0;
  localparam int unsigned STS_TRANSFER_BIT = 1;
  localparam int unsigned STS_MESSAGE_BIT  = 2;
  localparam int unsigned STS_STATE_LSB    = 3;

  // Value returned for an unmapped read and for an idle read data port.
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Synchroniser depth for pins.
  localparam int unsigned SYNC_STAGES = 2;

  // Channel sequencing, Gray coded along idle, request, transfer, release.
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_REQUEST  = 2'b01,
    ST_TRANSFER = 2'b11,
    ST_RELEASE  = 2'b10
  } dma_state_t;

  // A falling level between two samples.
  function automatic logic falls(input logic previous, input logic current);
    return previous & ~current;
  endfunction

  // A rising level between two samples.
  function automatic logic rises(input logic previous, input logic current);
    return ~previous & current;
  endfunction

endpackage : rx_dma_pkg

// *** pin_sample_if.sv ***
// Purpose: Carries synchronised host pin events from the sampler to the channel core.
// Assumes: Both ends run on the same clock.
// Notes:   The core tells the sampler which pin plays the data strobe.
interface pin_sample_if;
  logic direction_mode; // Fetch pin is a direction signal, store pin the strobe.
  logic ack_low;        // Synchronised acknowledge is asserted.
  logic strobe_fall;    // Data strobe of a read cycle went low.
  logic strobe_rise;    // Data strobe went back high.

  modport sampler (input direction_mode, output ack_low, output strobe_fall, output strobe_rise);
  modport core    (output direction_mode, input ack_low, input strobe_fall, input strobe_rise);
endinterface : pin_sample_if

// *** pin_sampler.sv ***
// Purpose: Synchronises the host strobe and acknowledge pins and finds strobe edges.
// Assumes: Pins are asynchronous to clock and active low.
// Notes:   Edges are taken from the second stage only, never from the first.
module pin_sampler
  import rx_dma_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     reset,
  input  wire logic     fetch_pin_n,
  input  wire logic     store_pin_n,
  input  wire logic     transfer_acknowledge_line_n,
  pin_sample_if.sampler link
);

  logic [2:0] sync_first;
  logic [2:0] sync_second;
  logic       strobe_previous;
  wire  logic fetch_level;
  wire  logic store_level;
  wire  logic strobe_level;
  wire  logic read_cycle;

  // Two flip-flops per pin; the first stage feeds only the second.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_first  <= 3'h7;
      sync_second <= 3'h7;
    end else begin
      sync_first  <= {transfer_acknowledge_line_n, store_pin_n, fetch_pin_n};
      sync_second <= sync_first;
    end
  end

  assign fetch_level  = sync_second[0];
  assign store_level  = sync_second[1];
  assign strobe_level = link.direction_mode ? store_level : fetch_level;
  // In direction mode a high fetch pin marks a read cycle; write cycles are not ours.
  assign read_cycle   = link.direction_mode ? fetch_level : 1'b1;

  // Previous strobe sample for edge detection.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strobe_previous <= 1'b1;
    end else begin
      strobe_previous <= strobe_level;
    end
  end

  assign link.ack_low     = ~sync_second[2];
  assign link.strobe_fall = falls(strobe_previous, strobe_level) & read_cycle;
  assign link.strobe_rise = rises(strobe_previous, strobe_level);

endmodule : pin_sampler

// *** receive_dma_read_channel.sv ***
// Purpose: Receive DMA read channel that empties completed HDLC receive messages to host memory.
// Assumes: One 20 MHz clock; host pins are asynchronous and active low; buffer side is on clock.
// Notes:   Each strobe costs about three clocks of latency through the synchronisers.
//
// The register addresses and strobed register access are this design's own decisions.
module receive_dma_read_channel
  import rx_dma_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [15:0] reg_address,
  input  wire logic [7:0]  reg_write_data,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_read_data,
  input  wire logic        fetch_pin_n,
  input  wire logic        store_pin_n,
  input  wire logic        transfer_acknowledge_line_n,
  output logic             transfer_request_line_n,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe,
  input  wire logic        message_ready,
  input  wire logic [7:0]  buffer_data,
  input  wire logic        buffer_last,
  output logic             buffer_pop,
  output logic      [2:0]  receive_channel_select
);

  pin_sample_if link ();

  logic [7:0]  config_word;
  dma_state_t  state;
  dma_state_t  next_state;
  logic        last_taken;
  wire  logic  config_hit;
  wire  logic  status_hit;
  wire  logic  config_write;
  wire  logic  receive_dma_reset;
  wire  logic  receive_dma_enable;
  wire  logic  soft_reset;
  wire  logic  channel_served;
  wire  logic  may_request;
  wire  logic  take_word;
  wire  logic  finish_word;
  wire  logic  abort;
  wire  logic [7:0] next_config;
  wire  logic [7:0] status_word;
  wire  logic [7:0] next_read_data;

  // Pin synchronisers and strobe edge finder.
  pin_sampler sampler (
    .clock                       (clock),
    .reset                       (reset),
    .fetch_pin_n                 (fetch_pin_n),
    .store_pin_n                 (store_pin_n),
    .transfer_acknowledge_line_n (transfer_acknowledge_line_n),
    .link                        (link.sampler)
  );

  // Register decode on the plain register port.
  assign config_hit   = (reg_address == CONFIG_OFFSET);
  assign status_hit   = (reg_address == STATUS_OFFSET);
  assign config_write = reg_write & config_hit;
  // Reserved bits are masked so they always read back as zero.
  assign next_config  = reg_write_data & CONFIG_WRITE_MASK;

  // Configuration register; every field starts at zero.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      config_word <= CONFIG_RESET;
    end else if (config_write) begin
      config_word <= next_config;
    end
  end

  // Configuration fields.
  assign receive_dma_reset  = config_word[CFG_RESET_BIT];
  assign receive_dma_enable = config_word[CFG_ENABLE_BIT];
  assign link.direction_mode = config_word[CFG_ROLE_BIT];

  // Only the transition to one resets; holding the bit at one does not keep the channel in reset.
  assign soft_reset = config_write & ~receive_dma_reset & next_config[CFG_RESET_BIT];

  // Reserved channel codes leave the interface silent rather than serving a channel that is absent.
  assign channel_served = (config_word[CFG_CHAN_LSB +: CFG_CHAN_W] == CHANNEL_ZERO);

  // A request may open only for a complete message on an enabled, served channel.
  assign may_request = receive_dma_enable & channel_served & message_ready;

  // Words are taken on each data strobe fall while the controller acknowledges.
  assign take_word   = (state == ST_TRANSFER) & link.ack_low & link.strobe_fall;
  assign finish_word = (state == ST_TRANSFER) & link.strobe_rise & last_taken;

  // Disabling or deselecting the channel, or a soft reset, drops any transfer at once.
  assign abort = soft_reset | ~receive_dma_enable | ~channel_served;

  // Next state of the channel sequencer.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (may_request) begin
          next_state = ST_REQUEST;
        end
      end
      ST_REQUEST: begin
        if (link.ack_low) begin
          next_state = ST_TRANSFER;
        end
      end
      ST_TRANSFER: begin
        if (finish_word) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Wait for acknowledge to go away so the next message starts a fresh handshake.
        if (!link.ack_low) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (abort) begin
      next_state = ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Remembers that the word on the bus closes the message.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      last_taken <= 1'b0;
    end else if (abort || state == ST_IDLE) begin
      last_taken <= 1'b0;
    end else if (take_word) begin
      last_taken <= buffer_last;
    end
  end

  // Request line is low from request until the last word of the message is done.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      transfer_request_line_n <= 1'b1;
    end else begin
      transfer_request_line_n <= ~(next_state == ST_REQUEST || next_state == ST_TRANSFER);
    end
  end

  // Buffer word goes onto the bus register and is popped in the same cycle.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      host_data_out <= 8'h00;
      buffer_pop    <= 1'b0;
    end else begin
      buffer_pop <= take_word & ~abort;
      if (take_word) begin
        host_data_out <= buffer_data;
      end
    end
  end

  // Bus is driven from the strobe fall until the strobe returns high.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      host_data_oe <= 1'b0;
    end else if (abort || link.strobe_rise || state != ST_TRANSFER) begin
      host_data_oe <= 1'b0;
    end else if (take_word) begin
      host_data_oe <= 1'b1;
    end
  end

  // Channel select is offered to the surrounding buffer logic.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      receive_channel_select <= CHANNEL_ZERO;
    end else begin
      receive_channel_select <= config_word[CFG_CHAN_LSB +: CFG_CHAN_W];
    end
  end

  // Status view of the live channel state.
  assign status_word = {3'h0, state, message_ready, (state == ST_TRANSFER), ~transfer_request_line_n};

  // Read mux; unmapped addresses return zero.
  assign next_read_data = !reg_read  ? READ_IDLE :
                          config_hit ? config_word :
                          status_hit ? status_word :
                          READ_IDLE;

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_read_data <= READ_IDLE;
    end else begin
      reg_read_data <= next_read_data;
    end
  end

endmodule : receive_dma_read_channel

// *** rx_dma_asserts.sv ***
// Purpose: Port level checks of the receive DMA read channel.
// Assumes: One clock, asynchronous active high reset.
// Notes:   Stored reset and role bits are shadowed from register writes.
module rx_dma_asserts
  import rx_dma_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [15:0] reg_address,
  input wire logic [7:0]  reg_write_data,
  input wire logic        reg_write,
  input wire logic        fetch_pin_n,
  input wire logic        store_pin_n,
  input wire logic        transfer_request_line_n,
  input wire logic [7:0]  host_data_out,
  input wire logic        host_data_oe,
  input wire logic [7:0]  buffer_data,
  input wire logic        buffer_pop,
  input wire logic [2:0]  receive_channel_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stored_reset;
  logic role;
  wire  cfg_wr = reg_write && reg_address == CONFIG_OFFSET;
  // Only a zero to one step of the reset bit acts, so its history is needed.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stored_reset <= 1'b0;
      role         <= 1'b0;
    end else if (cfg_wr) begin
      stored_reset <= reg_write_data[7];
      role         <= reg_write_data[5];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // The channel may re-request one cycle after a soft reset while still enabled, so only the next cycle is checked.
  a_soft_reset: assert property (cfg_wr && reg_write_data[7] && !stored_reset
    |=> transfer_request_line_n && !host_data_oe) else $error("soft reset ignored");
  a_disable_drop: assert property (cfg_wr && !reg_write_data[6]
    |-> ##2 transfer_request_line_n && !host_data_oe) else $error("disable ignored");
  a_oe_with_request: assert property (host_data_oe |-> !transfer_request_line_n)
    else $error("bus driven without request");
  a_pop_word: assert property (buffer_pop |-> host_data_oe && host_data_out == $past(buffer_data))
    else $error("word on bus differs from buffer");
  a_pop_single: assert property (buffer_pop |=> !buffer_pop)
    else $error("pop longer than one cycle");
  a_fetch_strobe: assert property (buffer_pop && !role |-> !$past(fetch_pin_n, 2))
    else $error("word without fetch strobe");
  a_store_strobe: assert property (buffer_pop && role
    |-> !$past(store_pin_n, 2) && $past(fetch_pin_n, 2)) else $error("word without store strobe");
  a_reserved_chan: assert property ((receive_channel_select != CHANNEL_ZERO)[*3]
    |-> transfer_request_line_n) else $error("request on unserved channel");
  a_chan_copy: assert property (cfg_wr
    |-> ##2 receive_channel_select == $past(reg_write_data[2:0], 2)) else $error("select not copied");
endmodule // rx_dma_asserts

bind receive_dma_read_channel rx_dma_asserts u_asserts (.clock, .reset, .reg_address, .reg_write_data,
  .reg_write, .fetch_pin_n, .store_pin_n, .transfer_request_line_n, .host_data_out, .host_data_oe,
  .buffer_data, .buffer_pop, .receive_channel_select);

// *** dma_ctrl_model.sv ***
// Purpose: External DMA controller that reads words off the host bus.
// Assumes: Pins active low; role picks the strobe pin.
// Notes:   The strobe low phase is longer in direction role to vary timing.
module dma_ctrl_model (
  input  wire logic       clock,
  input  wire logic       role,
  input  wire logic       request_n,
  input  wire logic [7:0] data,
  output logic            fetch_n,
  output logic            store_n,
  output logic            ack_n,
  output logic [7:0]      last_word,
  output int              words
);
  timeunit 1ns;
  timeprecision 1ns;
  // Answer a request, then take one word per strobe while it stands.
  initial begin
    fetch_n = 1'b1;
    store_n = 1'b1;
    ack_n = 1'b1;
    words = 0;
    forever begin
      @(posedge clock);
      if (!request_n) begin
        ack_n <= 1'b0;
        repeat (3) @(posedge clock);
        while (!request_n) begin
          if (role) store_n <= 1'b0;
          else fetch_n <= 1'b0;
          repeat (role ? 9 : 6) @(posedge clock);
          last_word = data;
          words++;
          fetch_n <= 1'b1;
          store_n <= 1'b1;
          repeat (6) @(posedge clock);
        end
        ack_n <= 1'b1;
      end
    end
  end
endmodule // dma_ctrl_model

// *** receive_dma_read_channel_tb_top.sv ***
// Purpose: Self-checking bench of the receive DMA read channel.
// Assumes: 20 MHz clock, buffer modelled by a small word table.
// Notes:   Partner model drives all host pins.
module receive_dma_read_channel_tb_top;
  import rx_dma_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, reset, reg_write, reg_read, role;
  logic       fetch_n, store_n, ack_n, req_n, oe, pop;
  logic [15:0] reg_address;
  logic [7:0] wdata, rdata, dout, last_word;
  logic [2:0] chan;
  logic [7:0] mem [8];
  int         idx, cnt, words, mismatches, checks;
  int         cycles = 0;
  wire        msg_ready = idx < cnt;
  wire [7:0]  bdata = mem[idx[2:0]];
  wire        blast = idx == cnt - 1;

  receive_dma_read_channel i_dut (.clock(clock), .reset(reset), .reg_address(reg_address),
    .reg_write_data(wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_read_data(rdata),
    .fetch_pin_n(fetch_n), .store_pin_n(store_n), .transfer_acknowledge_line_n(ack_n),
    .transfer_request_line_n(req_n), .host_data_out(dout), .host_data_oe(oe),
    .message_ready(msg_ready), .buffer_data(bdata), .buffer_last(blast), .buffer_pop(pop),
    .receive_channel_select(chan));
  // A released bus shows the inverse of the last word, so a late sample by the controller is caught.
  dma_ctrl_model i_dma (.clock(clock), .role(role), .request_n(req_n), .data(oe ? dout : ~dout),
    .fetch_n(fetch_n), .store_n(store_n), .ack_n(ack_n), .last_word(last_word), .words(words));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Buffer steps to the next word on each pop; a hang ends the run.
  always @(posedge clock) begin
    if (pop) idx <= idx + 1;
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_address <= a;
    wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_address <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic load(input int n);
    @(posedge clock);
    idx <= 0;
    cnt <= n;
  endtask
  task automatic t_regs;
    logic [7:0] d;
    chk("request", {oe, 6'h00, req_n}, 8'h01);
    rd(CONFIG_OFFSET, d);
    chk("config", d, 8'h00);
    @(posedge clock);
    #1 chk("read idle", rdata, READ_IDLE);
    wr(CONFIG_OFFSET, 8'h3F);
    rd(CONFIG_OFFSET, d);
    chk("config", d, 8'h27);
    chk("select", {5'h00, chan}, 8'h07);
    rd(16'h0000, d);
    chk("unmapped", d, 8'h00);
    wr(CONFIG_OFFSET, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_xfer(input logic r, input int n);
    int base;
    base = words;
    role <= r;
    wr(CONFIG_OFFSET, {2'b01, r, 5'h00});
    repeat (8) @(posedge clock);
    chk("idle request", {7'h00, req_n}, 8'h01);
    load(n);
    for (int i = 0; i < 20 && req_n !== 1'b0; i++) @(posedge clock);
    chk("request", {7'h00, req_n}, 8'h00);
    for (int i = 0; i < 400 && req_n !== 1'b1; i++) @(posedge clock);
    chk("words", 8'(words - base), 8'(n));
    chk("last word", last_word, mem[n - 1]);
    chk("pops", 8'(idx), 8'(n));
    wr(CONFIG_OFFSET, 8'h00);
    cnt <= 0;
    repeat (12) @(posedge clock);
    $display("test transfer done");
  endtask
  task automatic t_abort;
    logic [7:0] d;
    role <= 1'b0;
    load(4);
    wr(CONFIG_OFFSET, 8'h44);
    repeat (10) @(posedge clock);
    chk("reserved channel", {7'h00, req_n}, 8'h01);
    rd(STATUS_OFFSET, d);
    chk("status", d, 8'h04);
    wr(CONFIG_OFFSET, 8'h40);
    for (int i = 0; i < 20 && req_n !== 1'b0; i++) @(posedge clock);
    repeat (12) @(posedge clock);
    wr(CONFIG_OFFSET, 8'hC0);
    #1 chk("soft reset", {7'h00, req_n}, 8'h01);
    wr(CONFIG_OFFSET, 8'h00);
    repeat (3) @(posedge clock);
    chk("disabled", {oe, 6'h00, req_n}, 8'h01);
    cnt <= 0;
    repeat (30) @(posedge clock);
    $display("test abort done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hold reset for 16 cycles, then run the scenarios in turn.
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_address = 16'h0000;
    wdata = 8'h00;
    role = 1'b0;
    idx = 0;
    cnt = 0;
    mismatches = 0;
    checks = 0;
    for (int i = 0; i < 8; i++) mem[i] = 8'h3C + 8'(i * 17);
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_regs();
    t_xfer(1'b0, 3);
    t_xfer(1'b1, 2);
    t_xfer(1'b0, 1);
    t_abort();
    end_of_test();
  end
endmodule // receive_dma_read_channel_tb_top
